//--- usb_setup_regs.vh
/*
  register offsets, field positions and reset values of the setup request bank.
  assumes a 16-bit cpu port addressed by byte offset; included by bare name.
*/
`ifndef USB_SETUP_REGS_VH
`define USB_SETUP_REGS_VH
`define DEVICE_ADDRESS_OFFSET 8'h50
`define SETUP_REQUEST_TYPE_OFFSET 8'h54
`define SETUP_REQUEST_VALUE_OFFSET 8'h56
`define DEVICE_ADDRESS_WIDTH 7
`define DEVICE_ADDRESS_RESET 7'h00
`define REQUEST_CODE_MSB 15
`define REQUEST_CODE_LSB 8
`define REQUEST_KIND_MSB 7
`define REQUEST_KIND_LSB 0
`define SETUP_FIELD_RESET 16'h0000
`define READ_IDLE_VALUE 16'h0000
`endif

//--- setup_send_tracker.v
/*
  holds the host-role setup send-request flag.
  assumes the transfer engine pulses setup_done when the setup transaction ends.
*/
`include "usb_setup_regs.vh"
module setup_send_tracker (
  input wire clk,        // controller clock
  input wire rst,        // synchronous reset, active high
  input wire host_mode,  // 1 while host role is selected
  input wire set_req,    // software writes the flag to 1
  input wire setup_done, // setup transaction finished on the bus
  output reg busy        // setup send-request flag
);
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (!host_mode) begin
      busy <= 1'b0;
    end else if (busy && setup_done) begin
      busy <= 1'b0;
    end else if (set_req) begin
      busy <= 1'b1;
    end
  end
endmodule

//--- usb_setup_request_regs.v
/*
  device address and setup request fields of a dual-role usb controller.
  assumes a synchronous 16-bit cpu register port with read and write strobes,
  and a link engine that reports received setup fields and bus events as pulses.
*/
`include "usb_setup_regs.vh"
// Notes on behaviour
// - in peripheral role a normally completed set-address request loads the address field.
// - in peripheral role a usb bus reset clears the address field to zero.
// - in host role the address field is unused and nothing depends on it.
// - in host role software raises the send-request flag, then leaves the fields until it clears.
// - in peripheral role each received request code is kept readable in the request register.
// - in peripheral role software writes to the captured request fields are ignored.
// - the request register holds code in bits 15-8 and type in bits 7-0, both reset to zero.
// - the 16-bit value register holds the setup value per role and resets to zero.
// - the low byte of the value sits in bits 7-0 of the value register.
module usb_setup_request_regs (
  input wire clk,                // controller clock, 125 MHz
  input wire rst,                // synchronous reset, active high
  input wire host_mode,          // 1 host role, 0 peripheral role
  input wire [7:0] cpu_addr,     // byte offset of the register
  input wire cpu_wr,             // write strobe, one cycle
  input wire cpu_rd,             // read strobe, one cycle
  input wire [15:0] cpu_wdata,   // write data
  output reg [15:0] cpu_rdata,   // read data, valid the cycle after cpu_rd
  input wire setup_rx,           // setup fields received, one cycle
  input wire [7:0] rx_type,      // received request type byte
  input wire [7:0] rx_code,      // received request code byte
  input wire [15:0] rx_value,    // received value
  input wire set_addr_done,      // set-address status stage completed normally
  input wire [6:0] new_address,  // address carried by the set-address request
  input wire bus_reset,          // usb reset detected, one cycle
  input wire send_req_set,       // software sets the send-request flag
  input wire setup_done,         // host setup transaction finished
  output reg [6:0] device_address_field, // current device address
  output reg [15:0] setup_request_type_reg, // request code and type to the engine
  output reg [15:0] setup_request_value_reg, // value to the engine
  output reg setup_send_request_flag, // send request pending
  output reg send_start          // one-cycle start pulse to the engine
);
  wire flag;
  wire host_wr;
  wire sel_address;
  wire sel_type;
  wire sel_value;
  wire capture;
  wire address_clear;
  wire address_load;
  wire send_rise;
  wire [7:0] wdata_high;
  wire [7:0] wdata_low;
  wire [7:0] rx_value_high;
  wire [7:0] rx_value_low;
  reg flag_q;
  reg [6:0] next_device_address_field;
  reg [15:0] next_setup_request_type_reg;
  reg [15:0] next_setup_request_value_reg;
  reg [15:0] next_rdata;
  reg [15:0] next_cpu_rdata;
  reg next_setup_send_request_flag;
  reg next_flag_q;
  reg next_send_start;

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // request word: code byte above the kind byte
  function [15:0] pack_request;
    input [7:0] code;
    input [7:0] kind;
    begin
      pack_request = `SETUP_FIELD_RESET;
      pack_request[`REQUEST_CODE_MSB:`REQUEST_CODE_LSB] = code;
      pack_request[`REQUEST_KIND_MSB:`REQUEST_KIND_LSB] = kind;
    end
  endfunction

  // value word: low byte in bits 7-0
  function [15:0] pack_value;
    input [7:0] high;
    input [7:0] low;
    begin
      pack_value = {high, low};
    end
  endfunction

  // the upper bits of the address register read as zero
  function [15:0] widen_address;
    input [6:0] addr;
    begin
      widen_address = {9'h000, addr};
    end
  endfunction

  function [7:0] high_byte;
    input [15:0] word;
    begin
      high_byte = word[15:8];
    end
  endfunction

  function [7:0] low_byte;
    input [15:0] word;
    begin
      low_byte = word[7:0];
    end
  endfunction

  assign sel_address = hit(cpu_addr, `DEVICE_ADDRESS_OFFSET);
  assign sel_type = hit(cpu_addr, `SETUP_REQUEST_TYPE_OFFSET);
  assign sel_value = hit(cpu_addr, `SETUP_REQUEST_VALUE_OFFSET);

  assign wdata_high = high_byte(cpu_wdata);
  assign wdata_low = low_byte(cpu_wdata);
  assign rx_value_high = high_byte(rx_value);
  assign rx_value_low = low_byte(rx_value);

  // address and capture events count in peripheral role only
  assign capture = !host_mode && setup_rx;
  assign address_clear = !host_mode && bus_reset;
  // a usb reset beats a set-address finishing in the same cycle
  assign address_load = !host_mode && set_addr_done && !bus_reset;

  // fields are locked while a send is pending so the engine sees stable values
  assign host_wr = cpu_wr && host_mode && !flag;
  assign send_rise = flag && !flag_q;

  setup_send_tracker u_tracker (
    .clk(clk),
    .rst(rst),
    .host_mode(host_mode),
    .set_req(send_req_set),
    .setup_done(setup_done),
    .busy(flag)
  );

  always @* begin
    next_device_address_field = device_address_field;
    if (address_clear) begin
      next_device_address_field = `DEVICE_ADDRESS_RESET;
    end else if (address_load) begin
      next_device_address_field = new_address;
    end
  end

  // a capture and a host write cannot meet: they need opposite roles
  always @* begin
    next_setup_request_type_reg = setup_request_type_reg;
    if (capture) begin
      next_setup_request_type_reg = pack_request(rx_code, rx_type);
    end else if (host_wr && sel_type) begin
      next_setup_request_type_reg = pack_request(wdata_high, wdata_low);
    end
  end

  always @* begin
    next_setup_request_value_reg = setup_request_value_reg;
    if (capture) begin
      next_setup_request_value_reg = pack_value(rx_value_high, rx_value_low);
    end else if (host_wr && sel_value) begin
      next_setup_request_value_reg = pack_value(wdata_high, wdata_low);
    end
  end

  always @* begin
    next_rdata = `READ_IDLE_VALUE;
    if (sel_address) begin
      next_rdata = widen_address(device_address_field);
    end else if (sel_type) begin
      next_rdata = setup_request_type_reg;
    end else if (sel_value) begin
      next_rdata = setup_request_value_reg;
    end
  end

  // read data stays until the next read strobe, so software may sample it late
  always @* begin
    next_cpu_rdata = cpu_rdata;
    if (cpu_rd) begin
      next_cpu_rdata = next_rdata;
    end
  end

  // the port flag lags the internal one by a cycle; the start pulse marks its rise
  always @* begin
    next_setup_send_request_flag = flag;
    next_flag_q = flag;
    next_send_start = send_rise;
  end

  always @(posedge clk) begin
    if (rst) begin
      device_address_field <= `DEVICE_ADDRESS_RESET;
    end else begin
      device_address_field <= next_device_address_field;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      setup_request_type_reg <= `SETUP_FIELD_RESET;
      setup_request_value_reg <= `SETUP_FIELD_RESET;
    end else begin
      setup_request_type_reg <= next_setup_request_type_reg;
      setup_request_value_reg <= next_setup_request_value_reg;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cpu_rdata <= `READ_IDLE_VALUE;
    end else begin
      cpu_rdata <= next_cpu_rdata;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      setup_send_request_flag <= 1'b0;
      flag_q <= 1'b0;
      send_start <= 1'b0;
    end else begin
      setup_send_request_flag <= next_setup_send_request_flag;
      flag_q <= next_flag_q;
      send_start <= next_send_start;
    end
  end
endmodule

//--- setup_monitor.sv
/* assertions on the setup request bank ports.
   assumes binding to usb_setup_request_regs. */
module setup_monitor (
  input wire clk, rst, host_mode, setup_rx, set_addr_done, bus_reset,
  input wire send_req_set, setup_done, setup_send_request_flag,
  input wire [7:0] rx_type, rx_code,
  input wire [15:0] rx_value, setup_request_type_reg, setup_request_value_reg,
  input wire [6:0] new_address, device_address_field
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_addr_load: assert property (
    !host_mode && set_addr_done && !bus_reset |=> device_address_field == $past(new_address))
    else $error("address not loaded");
  a_addr_clear: assert property (
    !host_mode && bus_reset |=> device_address_field == 7'h00) else $error("address kept");
  a_addr_host: assert property (
    host_mode |=> $stable(device_address_field)) else $error("address moved in host role");
  a_code_capture: assert property (
    !host_mode && setup_rx |=> setup_request_type_reg == {$past(rx_code), $past(rx_type)})
    else $error("request not captured");
  a_value_capture: assert property (
    !host_mode && setup_rx |=> setup_request_value_reg == $past(rx_value))
    else $error("value not captured");
  a_fields_kept: assert property (
    !host_mode && !setup_rx |=>
    $stable(setup_request_type_reg) && $stable(setup_request_value_reg))
    else $error("fields written");
  a_flag_set: assert property (
    host_mode && send_req_set && !setup_done |-> ##2 setup_send_request_flag)
    else $error("flag not set");
  a_flag_clear: assert property (
    setup_send_request_flag && setup_done && !send_req_set |-> ##2 !setup_send_request_flag)
    else $error("flag not cleared");
endmodule
bind usb_setup_request_regs setup_monitor mon (
  .clk(clk), .rst(rst), .host_mode(host_mode), .setup_rx(setup_rx),
  .set_addr_done(set_addr_done), .bus_reset(bus_reset), .send_req_set(send_req_set),
  .setup_done(setup_done), .setup_send_request_flag(setup_send_request_flag),
  .rx_type(rx_type), .rx_code(rx_code), .rx_value(rx_value),
  .setup_request_type_reg(setup_request_type_reg),
  .setup_request_value_reg(setup_request_value_reg),
  .new_address(new_address), .device_address_field(device_address_field));

//--- usb_link_model.sv
/* link engine model: ends a host setup transaction gap cycles after start.
   assumes the bank's one-cycle send_start pulse. */
module usb_link_model #(parameter int gap = 6) (
  input wire logic clk, rst, send_start,
  output logic setup_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge clk) begin
    setup_done <= !rst && (cnt == 1);
    cnt <= rst ? 0 : send_start ? gap : (cnt > 0) ? cnt - 1 : 0;
  end
endmodule

//--- usb_setup_request_regs_bench.sv
/* testbench of the setup request bank with the link engine model.
   assumes the bound setup_monitor; inputs change on the falling edge. */
module usb_setup_request_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, host_mode = 0, cpu_wr = 0, cpu_rd = 0, setup_rx = 0;
  logic set_addr_done = 0, bus_reset = 0, send_req_set = 0, setup_done, send_start;
  logic setup_send_request_flag;
  logic [7:0] cpu_addr = 0, rx_type = 0, rx_code = 0;
  logic [15:0] cpu_wdata = 0, rx_value = 0, cpu_rdata, setup_request_type_reg;
  logic [15:0] setup_request_value_reg;
  logic [6:0] new_address = 0, device_address_field;
  int bad_count = 0, checks = 0;
  always #4 clk = ~clk;
  usb_setup_request_regs uut (
    .clk(clk), .rst(rst), .host_mode(host_mode), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .setup_rx(setup_rx),
    .rx_type(rx_type), .rx_code(rx_code), .rx_value(rx_value), .set_addr_done(set_addr_done),
    .new_address(new_address), .bus_reset(bus_reset), .send_req_set(send_req_set),
    .setup_done(setup_done), .device_address_field(device_address_field),
    .setup_request_type_reg(setup_request_type_reg),
    .setup_request_value_reg(setup_request_value_reg),
    .setup_send_request_flag(setup_send_request_flag), .send_start(send_start));
  usb_link_model link (.clk(clk), .rst(rst), .send_start(send_start), .setup_done(setup_done));
  task automatic check(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk) {cpu_wr, cpu_addr, cpu_wdata} = {1'b1, a, d};
    @(negedge clk) cpu_wr = 0;
  endtask
  // read data is held until the next read, so the late look is safe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk) {cpu_rd, cpu_addr} = {1'b1, a};
    @(negedge clk) cpu_rd = 0;
    @(negedge clk) check(cpu_rdata, exp);
  endtask
  task automatic peripheral_capture;
    rdchk(8'h54, 16'h0000);
    rdchk(8'h56, 16'h0000);
    @(negedge clk) {setup_rx, rx_type, rx_code, rx_value} = {1'b1, 8'h80, 8'h06, 16'h0102};
    @(negedge clk) setup_rx = 0;
    rdchk(8'h54, 16'h0680);
    rdchk(8'h56, 16'h0102);
    wr(8'h54, 16'hffff);
    wr(8'h56, 16'hffff);
    rdchk(8'h54, 16'h0680);
    rdchk(8'h56, 16'h0102);
    @(negedge clk) {set_addr_done, new_address} = {1'b1, 7'h2a};
    @(negedge clk) set_addr_done = 0;
    rdchk(8'h50, 16'h002a);
    @(negedge clk) {bus_reset, set_addr_done} = 2'b11;
    @(negedge clk) {bus_reset, set_addr_done} = 2'b00;
    rdchk(8'h50, 16'h0000);
  endtask
  task automatic host_send;
    @(negedge clk) {host_mode, set_addr_done, new_address} = {2'b11, 7'h15};
    @(negedge clk) set_addr_done = 0;
    check({9'h000, device_address_field}, 16'h0000);
    wr(8'h54, 16'h1234);
    wr(8'h56, 16'habcd);
    @(negedge clk) send_req_set = 1;
    @(negedge clk) send_req_set = 0;
    @(negedge clk) check({15'h0000, send_start}, 16'h0001);
    @(negedge clk) check({15'h0000, setup_send_request_flag}, 16'h0001);
    check({15'h0000, send_start}, 16'h0000);
    rdchk(8'h56, 16'habcd);
    // a write while the send is pending must be refused
    wr(8'h54, 16'h5555);
    repeat (10) @(negedge clk);
    check({15'h0000, setup_send_request_flag}, 16'h0000);
    rdchk(8'h54, 16'h1234);
  endtask
  task automatic complete_run;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    peripheral_capture;
    host_send;
    complete_run;
  end
  initial begin
    #20000;
    bad_count++;
    complete_run;
  end
endmodule
